// >>> irq_defines.svh
// addresses, field positions, reset values and masks of the interrupt controller
// assumes a 32-bit byte-addressed register bus
// Behaviour
// [RQ1] normal request is OR of normal pending
// [RQ2] pending bit set when requesting and enabled
// [RQ3] no priority encoder, no vector
// [RQ4] raw status follows peripheral request, read-only
// [RQ5] enable 1 passes source, 0 masks
// [RQ6] enable register writes ones only
// [RQ7] enable-clear ones clear matching enables
// [RQ8] fast bank mirrors normal bank
// [RQ9] fast request ORs fast pending, feeds bit0
// [RQ10] fast and normal enables mutually exclusive
// [RQ11] source may be disabled in both
// [RQ12] programmed interrupts bypass enable masks
// [RQ13] config bit1 drives normal bit1
// [RQ14] config bit2 drives fast bit1
// [RQ15] peripheral holds request beyond latency
// [RQ16] raw status zero after reset
// [RQ17] fixed source bit positions
// [RQ18] bit1 ignored in enable registers
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH
`define NORMAL_PENDING_ADDR 32'hffff0000
`define NORMAL_RAW_ADDR 32'hffff0004
`define NORMAL_ENABLE_ADDR 32'hffff0008
`define NORMAL_CLEAR_ADDR 32'hffff000c
`define SWI_CONFIG_ADDR 32'hffff0010
`define FAST_PENDING_ADDR 32'hffff0100
`define FAST_RAW_ADDR 32'hffff0104
`define FAST_ENABLE_ADDR 32'hffff0108
`define FAST_CLEAR_ADDR 32'hffff010c
`define FOLD_BIT 0
`define SWI_BIT 1
`define SWI_NORMAL_POS 1
`define SWI_FAST_POS 2
`define SRC_VALID_MASK 32'h000f7ffc
`define REG_RESET 32'h00000000
`endif

// >>> irq_pkg.sv
// types shared by the interrupt controller modules
// constants live in irq_defines.svh
package irq_pkg;
	typedef enum logic [3:0] {
		SEL_NPEND, SEL_NRAW, SEL_NEN, SEL_NCLR, SEL_SWI,
		SEL_FPEND, SEL_FRAW, SEL_FEN, SEL_FCLR, SEL_NONE
	} reg_sel_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] software_interrupt_config;
		logic normal_req;
		logic fast_req;
	} top_state_type;
endpackage

// >>> bank_if.sv
// signals between the controller top and one interrupt bank
// the top drives inputs, the bank returns its registered status
`timescale 1ns/1ps
interface bank_if #(parameter int WIDTH = 32);
	logic [WIDTH-1:0] src;
	logic [WIDTH-1:0] enable;
	logic sw_bit;
	logic fold;
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] pending;
	modport bank (input src, enable, sw_bit, fold, output raw, pending);
	modport ctrl (output src, enable, sw_bit, fold, input raw, pending);
endinterface

// >>> irq_bank.sv
// one bank: raw source status and masked pending status, both registered
// assumes enable never holds bits 0 or 1
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_bank import irq_pkg::*; #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] SRC_MASK = `SRC_VALID_MASK
) (
	input wire logic clock, // core clock
	input wire logic srst, // sync reset, active high
	bank_if.bank bus // bank signals
);
	typedef struct packed {
		logic [WIDTH-1:0] raw;
		logic [WIDTH-1:0] pending;
	} bank_state_type;
	bank_state_type st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		// [RQ4] raw follows sources
		st_next.raw = bus.src & SRC_MASK;
		// [RQ2] [RQ5] enabled requests pend
		st_next.pending = st_next.raw & bus.enable;
		// [RQ9] fast fold bit0
		st_next.raw[`FOLD_BIT] = bus.fold;
		st_next.pending[`FOLD_BIT] = bus.fold;
		// [RQ12] programmed bypasses mask
		st_next.raw[`SWI_BIT] = bus.sw_bit;
		st_next.pending[`SWI_BIT] = bus.sw_bit;
	end

	// [RQ16] status clears on reset
	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.raw = st_reg.raw;
	assign bus.pending = st_reg.pending;
endmodule

// >>> irq_enable_ctl.sv
// normal and fast enable masks with set and clear write strobes
// strobes are one-cycle pulses, at most one per cycle
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_enable_ctl import irq_pkg::*; #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] WR_MASK = `SRC_VALID_MASK
) (
	input wire logic clock, // core clock
	input wire logic srst, // sync reset, active high
	input wire logic set_normal, // write to normal enable
	input wire logic clr_normal, // write to normal enable clear
	input wire logic set_fast, // write to fast enable
	input wire logic clr_fast, // write to fast enable clear
	input wire logic [WIDTH-1:0] wdata, // write data
	output logic [WIDTH-1:0] normal_en, // normal mask
	output logic [WIDTH-1:0] fast_en // fast mask
);
	typedef struct packed {
		logic [WIDTH-1:0] normal_en;
		logic [WIDTH-1:0] fast_en;
	} enable_state_type;
	enable_state_type st_reg, st_next;
	logic [WIDTH-1:0] w;

	// [RQ18] bit1 not writable
	assign w = wdata & WR_MASK;

	always_comb begin
		st_next = st_reg;
		if (set_normal) begin
			// [RQ6] ones set, [RQ10] exclusive
			st_next.normal_en = st_reg.normal_en | w;
			st_next.fast_en = st_reg.fast_en & ~w;
		end else if (set_fast) begin
			// [RQ10] exclusive masks
			st_next.fast_en = st_reg.fast_en | w;
			st_next.normal_en = st_reg.normal_en & ~w;
		end else if (clr_normal) begin
			// [RQ7] [RQ11] ones clear, both may be off
			st_next.normal_en = st_reg.normal_en & ~w;
		end else if (clr_fast) begin
			// [RQ7] ones clear
			st_next.fast_en = st_reg.fast_en & ~w;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign normal_en = st_reg.normal_en;
	assign fast_en = st_reg.fast_en;
endmodule

// >>> irq_controller.sv
// two-level interrupt controller top: APB slave, programmed interrupts,
// request outputs to the core
// assumes peripheral requests are synchronous levels on src_req
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "irq_defines.svh"
module irq_controller import irq_pkg::*; #(
	parameter int WIDTH = 32
) (
	input wire logic clock, // core clock, 20 MHz
	input wire logic srst, // sync reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic [WIDTH-1:0] src_req, // peripheral request levels
	output logic normal_req, // normal request to core
	output logic fast_req // fast request to core
);
	top_state_type st_reg, st_next;
	reg_sel_type sel;
	logic wr_en;
	logic [31:0] rd_data;
	logic [WIDTH-1:0] normal_en;
	logic [WIDTH-1:0] fast_en;
	localparam logic [WIDTH-1:0] SRC_MASK = WIDTH'(`SRC_VALID_MASK);

	bank_if #(.WIDTH(WIDTH)) n_if ();
	bank_if #(.WIDTH(WIDTH)) f_if ();

	// full 32-bit compare: aliases would hide software bugs
	function automatic reg_sel_type decode(input logic [31:0] a);
		if (a == `NORMAL_PENDING_ADDR) begin
			decode = SEL_NPEND;
		end else if (a == `NORMAL_RAW_ADDR) begin
			decode = SEL_NRAW;
		end else if (a == `NORMAL_ENABLE_ADDR) begin
			decode = SEL_NEN;
		end else if (a == `NORMAL_CLEAR_ADDR) begin
			decode = SEL_NCLR;
		end else if (a == `SWI_CONFIG_ADDR) begin
			decode = SEL_SWI;
		end else if (a == `FAST_PENDING_ADDR) begin
			decode = SEL_FPEND;
		end else if (a == `FAST_RAW_ADDR) begin
			decode = SEL_FRAW;
		end else if (a == `FAST_ENABLE_ADDR) begin
			decode = SEL_FEN;
		end else if (a == `FAST_CLEAR_ADDR) begin
			decode = SEL_FCLR;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	assign sel = decode(paddr);
	// writes land at the edge that completes the access phase
	assign wr_en = psel && penable && st_reg.pready && pwrite;

	// [RQ3] plain status words, software picks the source
	always_comb begin
		rd_data = `REG_RESET;
		case (sel)
			SEL_NPEND: rd_data = 32'(n_if.pending);
			SEL_NRAW: rd_data = 32'(n_if.raw);
			SEL_NEN: rd_data = 32'(normal_en);
			SEL_FPEND: rd_data = 32'(f_if.pending);
			SEL_FRAW: rd_data = 32'(f_if.raw);
			SEL_FEN: rd_data = 32'(fast_en);
			SEL_SWI: begin
				rd_data[`SWI_FAST_POS:`SWI_NORMAL_POS] = st_reg.software_interrupt_config;
			end
			default: rd_data = `REG_RESET;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		// answer is prepared in the setup cycle so outputs stay registered
		if (psel && !penable) begin
			st_next.pready = 1'b1;
			st_next.pslverr = (sel == SEL_NONE);
			st_next.prdata = rd_data;
		end
		// [RQ13] [RQ14] programmed bits
		if (wr_en && sel == SEL_SWI) begin
			st_next.software_interrupt_config = pwdata[`SWI_FAST_POS:`SWI_NORMAL_POS];
		end
		// [RQ1] normal request OR
		st_next.normal_req = |n_if.pending;
		// [RQ9] fast request OR; bit0 is the fold itself, so it stays out
		st_next.fast_req = |f_if.pending[WIDTH-1:1];
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// [RQ8] fast bank mirrors normal
	// [RQ17] bit n is source n in both banks
	assign n_if.src = src_req;
	assign f_if.src = src_req;
	assign n_if.enable = normal_en;
	assign f_if.enable = fast_en;
	assign n_if.sw_bit = st_reg.software_interrupt_config[0];
	assign f_if.sw_bit = st_reg.software_interrupt_config[1];
	// [RQ9] fold into bit0 of both
	assign n_if.fold = st_reg.fast_req;
	assign f_if.fold = st_reg.fast_req;

	irq_bank #(.WIDTH(WIDTH), .SRC_MASK(WIDTH'(`SRC_VALID_MASK))) u_normal (
		.clock(clock),
		.srst(srst),
		.bus(n_if)
	);

	irq_bank #(.WIDTH(WIDTH), .SRC_MASK(WIDTH'(`SRC_VALID_MASK))) u_fast (
		.clock(clock),
		.srst(srst),
		.bus(f_if)
	);

	irq_enable_ctl #(.WIDTH(WIDTH), .WR_MASK(WIDTH'(`SRC_VALID_MASK))) u_enable (
		.clock(clock),
		.srst(srst),
		.set_normal(wr_en && sel == SEL_NEN),
		.clr_normal(wr_en && sel == SEL_NCLR),
		.set_fast(wr_en && sel == SEL_FEN),
		.clr_fast(wr_en && sel == SEL_FCLR),
		.wdata(pwdata[WIDTH-1:0]),
		.normal_en(normal_en),
		.fast_en(fast_en)
	);

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign normal_req = st_reg.normal_req;
	assign fast_req = st_reg.fast_req;

	// checks of the documented behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_wr_nen;
		wr_en && sel == SEL_NEN;
	endsequence

	sequence s_wr_nclr;
		wr_en && sel == SEL_NCLR;
	endsequence

	sequence s_wr_swi;
		wr_en && sel == SEL_SWI;
	endsequence

	sequence s_wr_fen;
		wr_en && sel == SEL_FEN;
	endsequence

	sequence s_wr_fclr;
		wr_en && sel == SEL_FCLR;
	endsequence

	property p_normal_or;
		##1 normal_req == $past(|n_if.pending);
	endproperty
	a_normal_or: assert property (p_normal_or) // [RQ1]
		else $error("normal request not OR of pending");

	property p_pending_mask;
		##1 n_if.pending[WIDTH-1:2] == (n_if.raw[WIDTH-1:2] & $past(normal_en[WIDTH-1:2]));
	endproperty
	a_pending_mask: assert property (p_pending_mask) // [RQ2]
		else $error("normal pending not raw and enable");

	property p_raw_follow;
		##1 n_if.raw[WIDTH-1:2] == $past(src_req[WIDTH-1:2] & SRC_MASK[WIDTH-1:2]);
	endproperty
	a_raw_follow: assert property (p_raw_follow) // [RQ4]
		else $error("raw status does not follow sources");

	property p_en_set;
		logic [WIDTH-1:0] old, d;
		(s_wr_nen, old = normal_en, d = pwdata[WIDTH-1:0])
			|=> normal_en == (old | (d & WIDTH'(`SRC_VALID_MASK)));
	endproperty
	a_en_set: assert property (p_en_set) // [RQ6]
		else $error("enable write did not only set bits");

	property p_en_clr;
		logic [WIDTH-1:0] old, d;
		(s_wr_nclr, old = normal_en, d = pwdata[WIDTH-1:0]) |=> normal_en == (old & ~d);
	endproperty
	a_en_clr: assert property (p_en_clr) // [RQ7]
		else $error("enable clear wrong");

	property p_fast_fold;
		##1 (fast_req == $past(|f_if.pending[WIDTH-1:1]))
			##1 (n_if.raw[0] == $past(fast_req) && f_if.pending[0] == $past(fast_req));
	endproperty
	a_fast_fold: assert property (p_fast_fold) // [RQ9]
		else $error("fast request or fold wrong");

	property p_exclusive;
		(normal_en & fast_en) == '0;
	endproperty
	a_exclusive: assert property (p_exclusive) // [RQ10]
		else $error("source enabled in both banks");

	property p_swi;
		logic [1:0] v;
		(s_wr_swi, v = pwdata[2:1]) |=> ##1
			(n_if.pending[1] == v[0] && n_if.raw[1] == v[0]
			&& f_if.pending[1] == v[1] && f_if.raw[1] == v[1]);
	endproperty
	a_swi: assert property (p_swi) // [RQ13]
		else $error("programmed interrupt not reflected");

	property p_bit1_mask;
		normal_en[1] == 1'b0 && fast_en[1] == 1'b0;
	endproperty
	a_bit1_mask: assert property (p_bit1_mask) // [RQ18]
		else $error("bit1 writable in an enable mask");

	property p_reset_raw;
		@(posedge clock) disable iff (1'b0) srst |=> n_if.raw == '0 && normal_en == '0;
	endproperty
	a_reset_raw: assert property (p_reset_raw) // [RQ16]
		else $error("raw status not zero after reset");

	property p_ready;
		s_setup |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("apb ready timing wrong");

	property p_fast_raw_follow;
		##1 f_if.raw[WIDTH-1:2] == $past(src_req[WIDTH-1:2] & SRC_MASK[WIDTH-1:2]);
	endproperty
	a_fast_raw_follow: assert property (p_fast_raw_follow) // [RQ8]
		else $error("fast raw status does not follow sources");

	property p_fast_pending_mask;
		##1 f_if.pending[WIDTH-1:2] == (f_if.raw[WIDTH-1:2] & $past(fast_en[WIDTH-1:2]));
	endproperty
	a_fast_pending_mask: assert property (p_fast_pending_mask) // [RQ8]
		else $error("fast pending not raw and enable");

	property p_fen_set;
		logic [WIDTH-1:0] old_n, old_f, d;
		(s_wr_fen, old_n = normal_en, old_f = fast_en, d = pwdata[WIDTH-1:0] & SRC_MASK)
			|=> fast_en == (old_f | d) && normal_en == (old_n & ~d);
	endproperty
	a_fen_set: assert property (p_fen_set) // [RQ10]
		else $error("fast enable write wrong or not exclusive");

	property p_nen_excl;
		logic [WIDTH-1:0] old_f, d;
		(s_wr_nen, old_f = fast_en, d = pwdata[WIDTH-1:0] & SRC_MASK)
			|=> fast_en == (old_f & ~d);
	endproperty
	a_nen_excl: assert property (p_nen_excl) // [RQ10]
		else $error("normal enable write did not clear fast bits");

	property p_fen_clr;
		logic [WIDTH-1:0] old_n, old_f, d;
		(s_wr_fclr, old_n = normal_en, old_f = fast_en, d = pwdata[WIDTH-1:0])
			|=> fast_en == (old_f & ~d) && normal_en == old_n;
	endproperty
	a_fen_clr: assert property (p_fen_clr) // [RQ7]
		else $error("fast enable clear wrong");

	property p_fold_both;
		n_if.raw[0] == f_if.raw[0] && n_if.pending[0] == n_if.raw[0] && f_if.pending[0] == f_if.raw[0];
	endproperty
	a_fold_both: assert property (p_fold_both) // [RQ9]
		else $error("fold bit differs between banks");

	property p_reserved;
		(n_if.raw[WIDTH-1:2] & ~SRC_MASK[WIDTH-1:2]) == '0 && (f_if.raw[WIDTH-1:2] & ~SRC_MASK[WIDTH-1:2]) == '0;
	endproperty
	a_reserved: assert property (p_reserved) // [RQ17]
		else $error("reserved source bit set in raw status");

	property p_swi_fast;
		s_wr_swi ##0 pwdata[`SWI_FAST_POS] |-> ##3 fast_req;
	endproperty
	a_swi_fast: assert property (p_swi_fast) // [RQ14]
		else $error("programmed fast interrupt did not raise fast request");

	property p_swi_read;
		s_setup ##0 sel == SEL_SWI |=> prdata == {29'h0, $past(st_reg.software_interrupt_config), 1'b0};
	endproperty
	a_swi_read: assert property (p_swi_read) // [RQ14]
		else $error("programmed interrupt config read wrong");

	property p_slverr;
		s_setup |=> pslverr == $past(sel == SEL_NONE);
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("error response does not match address");

	property p_rdata_hold;
		!(psel && !penable) |=> $stable(prdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed outside setup");

	property p_idle_ready;
		!psel |=> !pready;
	endproperty
	a_idle_ready: assert property (p_idle_ready)
		else $error("ready without select");

	property p_en_hold;
		!(wr_en && (sel == SEL_NEN || sel == SEL_NCLR || sel == SEL_FEN || sel == SEL_FCLR))
			|=> $stable(normal_en) && $stable(fast_en);
	endproperty
	a_en_hold: assert property (p_en_hold) // [RQ6]
		else $error("enable mask changed without enable write");

	property p_swi_hold;
		!(wr_en && sel == SEL_SWI)
			|=> $stable(st_reg.software_interrupt_config);
	endproperty
	a_swi_hold: assert property (p_swi_hold) // [RQ13]
		else $error("programmed interrupt config changed without write");
endmodule

// >>> periph_model.sv
// peripheral request lines as seen by the interrupt controller
// assumes raise and drop pulses come from the bench, one cycle each
`timescale 1ns/1ps
module periph_model (
	input wire logic clock, // core clock
	input wire logic srst, // sync reset, active high
	input wire logic [31:0] raise, // peripherals flag an event
	input wire logic [31:0] drop, // peripheral flag cleared by software
	output logic [31:0] src_req // request levels to the controller
);
	// held until cleared
	// a level, not a pulse: a short blip could slip past the controller
	always_ff @(posedge clock) begin
		if (srst) begin
			src_req <= 32'h0;
		end else begin
			src_req <= (src_req | raise) & ~drop;
		end
	end
endmodule

// >>> tb_dual_level_interrupt_controller.sv
// self-checking bench for the two-level interrupt controller
// assumes an apb slave that answers in its own time and a peripheral model on src_req
`timescale 1ns/1ps
`include "irq_defines.svh"
module tb_dual_level_interrupt_controller import irq_pkg::*;;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] raise = 32'h0;
	logic [31:0] drop = 32'h0;
	logic [31:0] prdata, rd, src_req;
	logic pready, pslverr, normal_req, fast_req, err;
	int n_errors = 0;
	int tests_run = 0;
	always #25 clock = ~clock;
	irq_controller dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_req(src_req), .normal_req(normal_req), .fast_req(fast_req));
	periph_model peri (.clock(clock), .srst(srst), .raise(raise), .drop(drop),
		.src_req(src_req));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clock);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		check(rd, exp);
	endtask
	// the programmed fast bit needs four edges after the write edge to reach normal_req
	task automatic settle();
		repeat (8) @(posedge clock);
	endtask
	task automatic src(input logic [31:0] up, input logic [31:0] dn);
		@(posedge clock);
		raise <= up;
		drop <= dn;
		@(posedge clock);
		raise <= 32'h0;
		drop <= 32'h0;
		settle();
	endtask
	task automatic t_reset();
		logic [31:0] a [9];
		a = '{`NORMAL_PENDING_ADDR, `NORMAL_RAW_ADDR, `NORMAL_ENABLE_ADDR, `NORMAL_CLEAR_ADDR,
			`SWI_CONFIG_ADDR, `FAST_PENDING_ADDR, `FAST_RAW_ADDR, `FAST_ENABLE_ADDR,
			`FAST_CLEAR_ADDR};
		foreach (a[i]) rdchk(a[i], `REG_RESET);
		rdchk(32'hffff0020, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_normal();
		apb(1'b1, `NORMAL_ENABLE_ADDR, 32'h4);
		src(32'h00108004, 32'h0);
		rdchk(`NORMAL_RAW_ADDR, 32'h4);
		rdchk(`NORMAL_PENDING_ADDR, 32'h4);
		check({31'h0, normal_req}, 32'h1);
		apb(1'b1, `NORMAL_ENABLE_ADDR, 32'h2);
		rdchk(`NORMAL_ENABLE_ADDR, 32'h4);
		apb(1'b1, `NORMAL_CLEAR_ADDR, 32'h6);
		settle();
		rdchk(`NORMAL_ENABLE_ADDR, 32'h0);
		rdchk(`NORMAL_PENDING_ADDR, 32'h0);
		check({31'h0, normal_req}, 32'h0);
		src(32'h0, 32'h00108004);
		rdchk(`NORMAL_RAW_ADDR, 32'h0);
		$display("test normal done");
	endtask
	task automatic t_fast();
		apb(1'b1, `NORMAL_ENABLE_ADDR, 32'h8);
		apb(1'b1, `FAST_ENABLE_ADDR, 32'h8);
		rdchk(`NORMAL_ENABLE_ADDR, 32'h0);
		apb(1'b1, `FAST_ENABLE_ADDR, 32'h10);
		apb(1'b1, `FAST_CLEAR_ADDR, 32'h10);
		rdchk(`FAST_ENABLE_ADDR, 32'h8);
		src(32'h8, 32'h0);
		check({31'h0, fast_req}, 32'h1);
		rdchk(`FAST_PENDING_ADDR, 32'h9);
		rdchk(`NORMAL_PENDING_ADDR, 32'h1);
		check({31'h0, normal_req}, 32'h1);
		apb(1'b1, `NORMAL_ENABLE_ADDR, 32'h8);
		rdchk(`FAST_ENABLE_ADDR, 32'h0);
		apb(1'b1, `NORMAL_CLEAR_ADDR, 32'h8);
		rdchk(`NORMAL_ENABLE_ADDR, 32'h0);
		settle();
		check({30'h0, fast_req, normal_req}, 32'h0);
		src(32'h0, 32'h8);
		$display("test fast done");
	endtask
	task automatic t_swi();
		apb(1'b1, `SWI_CONFIG_ADDR, 32'h2);
		settle();
		rdchk(`NORMAL_PENDING_ADDR, 32'h2);
		rdchk(`NORMAL_RAW_ADDR, 32'h2);
		check({31'h0, normal_req}, 32'h1);
		apb(1'b1, `SWI_CONFIG_ADDR, 32'hffffffff);
		rdchk(`SWI_CONFIG_ADDR, 32'h6);
		apb(1'b1, `SWI_CONFIG_ADDR, 32'h4);
		settle();
		rdchk(`FAST_RAW_ADDR, 32'h3);
		rdchk(`FAST_PENDING_ADDR, 32'h3);
		rdchk(`NORMAL_RAW_ADDR, 32'h1);
		check({31'h0, fast_req}, 32'h1);
		apb(1'b1, `SWI_CONFIG_ADDR, 32'h0);
		settle();
		check({30'h0, fast_req, normal_req}, 32'h0);
		$display("test software done");
	endtask
	task automatic t_mid_reset();
		apb(1'b1, `NORMAL_ENABLE_ADDR, 32'h4);
		apb(1'b1, `SWI_CONFIG_ADDR, 32'h6);
		settle();
		check({31'h0, fast_req}, 32'h1);
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rdchk(`NORMAL_ENABLE_ADDR, `REG_RESET);
		rdchk(`SWI_CONFIG_ADDR, `REG_RESET);
		rdchk(`NORMAL_RAW_ADDR, `REG_RESET);
		check({30'h0, fast_req, normal_req}, 32'h0);
		$display("test mid reset done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#(5000 * 50);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		t_reset();
		t_normal();
		t_fast();
		t_swi();
		t_mid_reset();
		summarize();
	end
endmodule
